// ==== rtl/tsim_defines.vh ====
// Register offsets, field positions and reset values of the channel
// status and interrupt block. Assumes a 32-bit Avalon-MM word bus.
`ifndef TSIM_DEFINES_VH
`define TSIM_DEFINES_VH

`define TSIM_ADDR_W 4
`define TSIM_OFF_STATUS 4'h0
`define TSIM_OFF_IEN_SET 4'h4
`define TSIM_OFF_IEN_CLR 4'h8
`define TSIM_OFF_MASK 4'hc
`define TSIM_OFF_MODE 4'h0

`define TSIM_EV_OVF 0
`define TSIM_EV_LOVR 1
`define TSIM_EV_CPA 2
`define TSIM_EV_CPB 3
`define TSIM_EV_CPC 4
`define TSIM_EV_LDA 5
`define TSIM_EV_LDB 6
`define TSIM_EV_ETRG 7
`define TSIM_NEV 8

`define TSIM_ST_CLK 16
`define TSIM_ST_PINA 17
`define TSIM_ST_PINB 18

`define TSIM_WAVE_ONLY 8'h0c
`define TSIM_CAPT_ONLY 8'h62
`define TSIM_RST_FLAGS 8'h00
`define TSIM_RST_MASK 8'h00
`define TSIM_RST_DATA 32'h0000_0000

`endif

// ==== rtl/tsim_flag.v ====
// One sticky event flag with clear-on-read.
// Assumes set and read-clear pulses synchronous to clk.
`timescale 1ns/1ps
module tsim_flag (
    input wire clk,
    input wire rstn,
    input wire set_en,
    input wire rd_clr,
    output reg flag_r
);
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_r <= 1'b0;
        end else if (set_en) begin
            // Set wins over a read in the same cycle
            flag_r <= 1'b1;
        end else if (rd_clr) begin
            flag_r <= 1'b0;
        end
    end
endmodule

// ==== rtl/tsim_mask.v ====
// Interrupt mask with write-one-to-set and write-one-to-clear ports.
// Assumes single-cycle write strobes from the bus slave.
`timescale 1ns/1ps
`include "tsim_defines.vh"
module tsim_mask (
    input wire clk,
    input wire rstn,
    input wire set_we,
    input wire clr_we,
    input wire [7:0] wdata,
    output reg [7:0] mask_r
);
    reg [7:0] mask_nxt;

    always @* begin
        mask_nxt = mask_r;
        if (set_we) begin
            mask_nxt = mask_nxt | wdata;
        end
        if (clr_we) begin
            mask_nxt = mask_nxt & ~wdata;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_r <= `TSIM_RST_MASK;
        end else begin
            mask_r <= mask_nxt;
        end
    end
endmodule

// ==== rtl/tsim_top.v ====
// Status, interrupt mask and interrupt line of one timer channel.
// Assumes event pulses from the counter datapath, synchronous to clk.
// How it works
// - B compare flag, waveform mode only
// - C compare flag in both modes
// - A load flag, capture mode only
// - B load flag, capture mode only
// - External trigger flag, cleared on read
// - Clock status bit shows counter clock
// - Pin A mirror: sampled or driven level
// - Pin B mirror: sampled or driven level
// - Enable write of one sets mask
// - Disable write of one clears mask
// - Disable bits not qualified by mode
// - Mask register reads enable state
// - Mode bit one means waveform
// - Overflow flag held until status read
// - Load overrun flag in capture mode
// - A compare flag, waveform mode only
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tsim_defines.vh"
module tsim_top (
    input wire clk,
    input wire rstn,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire wave_mode,
    input wire clk_enabled,
    input wire wave_pin_a_in,
    input wire wave_pin_b_in,
    input wire wave_pin_a_drv,
    input wire wave_pin_b_drv,
    input wire ev_overflow,
    input wire ev_a_compare,
    input wire ev_b_compare,
    input wire ev_c_compare,
    input wire ev_a_load,
    input wire ev_b_load,
    input wire ev_ext_trigger,
    input wire ev_reg_a_read,
    input wire ev_reg_b_read,
    output reg irq
);
    // Event flags and mask, bit order as in the status word
    wire [7:0] flags;
    wire [7:0] mask;
    wire [3:0] sel;
    wire [7:0] keep;
    reg [7:0] ev_set;
    reg unread_a_r;
    reg unread_b_r;
    // Access decode and handshake
    reg bus_state_r;
    reg bus_state_nxt;
    reg [31:0] rdata_nxt;
    reg wait_nxt;
    reg irq_nxt;
    wire req;
    wire st_rd;
    wire ien_we;
    wire idr_we;

    // Bus handshake states
    localparam BUS_IDLE = 1'b0;
    localparam BUS_ACK = 1'b1;

    // Positions in the one-hot register select
    localparam SEL_STATUS = 0;
    localparam SEL_IEN_SET = 1;
    localparam SEL_IEN_CLR = 2;
    localparam SEL_MASK = 3;

    // Address decode shared by the write strobes and the read mux
    function [3:0] reg_sel;
        input [3:0] addr;
        begin
            case (addr)
                `TSIM_OFF_STATUS: begin
                    reg_sel = 4'h1;
                end
                `TSIM_OFF_IEN_SET: begin
                    reg_sel = 4'h2;
                end
                `TSIM_OFF_IEN_CLR: begin
                    reg_sel = 4'h4;
                end
                `TSIM_OFF_MASK: begin
                    reg_sel = 4'h8;
                end
                default: begin
                    reg_sel = 4'h0;
                end
            endcase
        end
    endfunction

    // Event bits that the given mode can report
    function [7:0] mode_keep;
        input wave;
        begin
            if (wave) begin
                mode_keep = ~`TSIM_CAPT_ONLY;
            end else begin
                mode_keep = ~`TSIM_WAVE_ONLY;
            end
        end
    endfunction

    // Pin mirror source: driven level in waveform mode, pin otherwise
    function pin_view;
        input wave;
        input drv;
        input smp;
        begin
            if (wave) begin
                pin_view = drv;
            end else begin
                pin_view = smp;
            end
        end
    endfunction

    assign sel = reg_sel(avs_address);

    assign keep = mode_keep(wave_mode);

    // One wait state: a request is taken on the first edge and answered
    // on the second; the idle edge after the answer keeps a request that
    // is still held from being taken twice
    always @* begin
        bus_state_nxt = bus_state_r;
        case (bus_state_r)
            BUS_IDLE: begin
                // Take the request on this edge
                if (avs_read | avs_write) begin
                    bus_state_nxt = BUS_ACK;
                end
            end
            BUS_ACK: begin
                // Answer stands; the next edge takes nothing
                bus_state_nxt = BUS_IDLE;
            end
            default: begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    assign req = (avs_read | avs_write) & (bus_state_r == BUS_IDLE);
    // A status read clears the flags at the edge that latches the word
    assign st_rd = req & avs_read & sel[SEL_STATUS];
    assign ien_we = req & avs_write & avs_byteenable[0] &
                    sel[SEL_IEN_SET];
    assign idr_we = req & avs_write & avs_byteenable[0] &
                    sel[SEL_IEN_CLR];

    always @* begin
        wait_nxt = ~req;
        // level interrupt
        // A stale flag of the other mode reads as zero, so it must not
        // hold the line up either
        irq_nxt = |(flags & mask & keep);
    end

    always @* begin
        ev_set = 8'h00;
        ev_set[`TSIM_EV_OVF] = ev_overflow;
        ev_set[`TSIM_EV_LOVR] = ~wave_mode &
            ((ev_a_load & unread_a_r) | (ev_b_load & unread_b_r));
        ev_set[`TSIM_EV_CPA] = wave_mode & ev_a_compare;
        ev_set[`TSIM_EV_CPB] = wave_mode & ev_b_compare;
        ev_set[`TSIM_EV_CPC] = ev_c_compare;
        ev_set[`TSIM_EV_LDA] = ~wave_mode & ev_a_load;
        ev_set[`TSIM_EV_LDB] = ~wave_mode & ev_b_load;
        ev_set[`TSIM_EV_ETRG] = ev_ext_trigger;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `TSIM_NEV; gi = gi + 1) begin : g_flag
            tsim_flag u_flag (
                .clk(clk),
                .rstn(rstn),
                .set_en(ev_set[gi]),
                .rd_clr(st_rd),
                .flag_r(flags[gi])
            );
        end
    endgenerate

    // unqualified disable: a mask bit whose source is idle in
    // this mode is still cleared, since the flag cannot be set anyway
    tsim_mask u_mask (
        .clk(clk),
        .rstn(rstn),
        .set_we(ien_we),
        .clr_we(idr_we),
        .wdata(avs_writedata[7:0]),
        .mask_r(mask)
    );

    // Loads since the last read of the loaded register
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            unread_a_r <= 1'b0;
            unread_b_r <= 1'b0;
        end else begin
            if (ev_a_load) begin
                unread_a_r <= 1'b1;
            end else if (ev_reg_a_read) begin
                unread_a_r <= 1'b0;
            end
            if (ev_b_load) begin
                unread_b_r <= 1'b1;
            end else if (ev_reg_b_read) begin
                unread_b_r <= 1'b0;
            end
        end
    end

    always @* begin
        rdata_nxt = `TSIM_RST_DATA;
        case (sel)
            4'h1: begin
                // Mode gating hides flags of the other mode after a switch
                rdata_nxt[7:0] = flags & keep;
                rdata_nxt[`TSIM_ST_CLK] = clk_enabled;
                rdata_nxt[`TSIM_ST_PINA] = pin_view(wave_mode,
                    wave_pin_a_drv, wave_pin_a_in);
                rdata_nxt[`TSIM_ST_PINB] = pin_view(wave_mode,
                    wave_pin_b_drv, wave_pin_b_in);
            end
            4'h8: begin
                rdata_nxt[7:0] = mask;
            end
            default: begin
                // Write-only and unmapped offsets read as zero
                rdata_nxt = `TSIM_RST_DATA;
            end
        endcase
    end

    // Handshake state
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_state_r <= BUS_IDLE;
        end else begin
            bus_state_r <= bus_state_nxt;
        end
    end

    // Waitrequest also stands high while idle, so a new request never
    // needs it to fall combinationally
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= wait_nxt;
        end
    end

    // Read data stand until the next read is taken
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= `TSIM_RST_DATA;
        end else if (req & avs_read) begin
            avs_readdata <= rdata_nxt;
        end
    end

    // Registered so the line never glitches toward the interrupt controller
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_nxt;
        end
    end
endmodule

// ==== dv/tsim_top_chk.sv ====
// Concurrent checks on the bus timing and status reads of tsim_top.
// Bound into tsim_top; one clock domain, async active-low reset.
`timescale 1ns/1ps
module tsim_chk (
    input wire clk,
    input wire rstn,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire wave_mode,
    input wire clk_enabled,
    input wire wave_pin_a_in,
    input wire wave_pin_b_in,
    input wire wave_pin_a_drv,
    input wire wave_pin_b_drv,
    input wire irq
);
    reg [1:0] pins_r;
    wire st = avs_read && avs_address == 4'h0 && !avs_waitrequest;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Pin levels the status word should have latched one edge earlier
    always @(posedge clk) begin
        pins_r <= wave_mode ? {wave_pin_b_drv, wave_pin_a_drv}
            : {wave_pin_b_in, wave_pin_a_in};
    end
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low twice");
    chk_rd_answer: assert property ($rose(avs_read) |=> !avs_waitrequest)
        else $error("read answer late");
    chk_wr_answer: assert property ($rose(avs_write) |=> !avs_waitrequest)
        else $error("write answer late");
    chk_idle_wait: assert property (!avs_read && !avs_write
        |=> avs_waitrequest) else $error("wait low when idle");
    chk_capt_zero: assert property (st && !$past(wave_mode)
        |-> avs_readdata[3:2] == 2'h0) else $error("compare flag set");
    chk_wave_zero: assert property (st && $past(wave_mode)
        |-> {avs_readdata[6:5], avs_readdata[1]} == 3'h0)
        else $error("load flag set");
    chk_clk_status: assert property (st
        |-> avs_readdata[16] == $past(clk_enabled)) else $error("clock bit");
    chk_pin_mirror: assert property (st
        |-> avs_readdata[18:17] == pins_r) else $error("pin mirror");
    cover property (st && avs_readdata[7:0] != 8'h00);
    cover property ($rose(irq));
    cover property ($fell(irq));
endmodule
bind tsim_top tsim_chk tsim_chk_i (.clk, .rstn, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .wave_mode, .clk_enabled,
    .wave_pin_a_in, .wave_pin_b_in, .wave_pin_a_drv, .wave_pin_b_drv, .irq);

// ==== dv/tsim_top_tb_top.sv ====
// Bench for tsim_top: register bus, event flags, mask and irq.
// Drives every port itself; waits on waitrequest for each access.
`timescale 1ns/1ps
module tsim_top_tb_top;
    logic clk = 0, rstn = 0, avs_read = 0, avs_write = 0;
    logic wave_mode = 1, clk_enabled = 0, avs_waitrequest, irq;
    logic wave_pin_a_in = 0, wave_pin_b_in = 1;
    logic wave_pin_a_drv = 1, wave_pin_b_drv = 0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [9:0] ev = 10'h000;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    always #5 clk = ~clk;
    tsim_top tsim_top_i (.clk, .rstn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
        .avs_waitrequest, .wave_mode, .clk_enabled, .wave_pin_a_in,
        .wave_pin_b_in, .wave_pin_a_drv, .wave_pin_b_drv,
        .ev_overflow(ev[0]), .ev_a_compare(ev[2]), .ev_b_compare(ev[3]),
        .ev_c_compare(ev[4]), .ev_a_load(ev[5]), .ev_b_load(ev[6]),
        .ev_ext_trigger(ev[7]), .ev_reg_a_read(ev[8]),
        .ev_reg_b_read(ev[9]), .irq);
    task complete_run;
        $display("errors %0d checks %0d", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Leading edge keeps a gap so a request never rises where one fell
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task rdc(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        cmp(rd, exp);
    endtask
    task pulse(input logic [9:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 10'h000;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            complete_run;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rdc(4'h0, 32'h0002_0000);
        rdc(4'hc, 32'h0000_0000);
        rdc(4'h2, 32'h0000_0000);
        clk_enabled <= 1'b1;
        pulse(10'h0fd);
        rdc(4'h0, 32'h0003_009d);
        rdc(4'h0, 32'h0003_0000);
        wave_mode <= 1'b0;
        clk_enabled <= 1'b0;
        pulse(10'h07c);
        pulse(10'h020);
        rdc(4'h0, 32'h0004_0072);
        pulse(10'h100);
        pulse(10'h020);
        pulse(10'h100);
        pulse(10'h020);
        rdc(4'h0, 32'h0004_0020);
        bus(1'b1, 4'h4, 32'h0000_00ff);
        rdc(4'hc, 32'h0000_00ff);
        bus(1'b1, 4'h8, 32'h0000_000f);
        rdc(4'hc, 32'h0000_00f0);
        bus(1'b1, 4'h4, 32'h0000_0000);
        bus(1'b1, 4'h8, 32'h0000_0000);
        rdc(4'hc, 32'h0000_00f0);
        pulse(10'h001);
        repeat (3) @(posedge clk);
        cmp({31'h0, irq}, 32'h0);
        pulse(10'h080);
        repeat (3) @(posedge clk);
        cmp({31'h0, irq}, 32'h1);
        rdc(4'h0, 32'h0004_0081);
        repeat (3) @(posedge clk);
        cmp({31'h0, irq}, 32'h0);
        complete_run;
    end
endmodule
